// File: dv/ccs_sense_model.sv
// Purpose: sensor side model driving modulator, touch and button levels
// Assumes: levels change on the falling clock edge
// Notes: idle electrode is nulled, so the modulator bit is high half the time
`timescale 1ns/1ps
module ccs_sense_model (
	// Requests from the bench
	input  wire logic       clk,
	input  wire logic       touch_req,
	input  wire logic [1:0] btn_req,
	// Electrode side levels
	output logic            mod_bit = 1'b0,
	output logic            touch   = 1'b0,
	output logic            prox    = 1'b0,
	output logic            btn_pos = 1'b0,
	output logic            btn_neg = 1'b0
);
	logic [6:0] per_cnt = 7'h00;
	// Levels move off the sampling edge to avoid races
	always @(negedge clk) begin
		// One toggle per sample period, so even stages average to midscale
		per_cnt <= (per_cnt == 7'h63) ? 7'h00 : per_cnt + 7'h01;
		if (per_cnt == 7'h63)
			mod_bit <= ~mod_bit;
		touch <= touch_req;
		prox <= 1'b0;
		{btn_pos, btn_neg} <= btn_req; // Bit 1 is the positive button
	end
endmodule

// File: dv/ccs_seq_assertions.sv
// Purpose: port checks for the conversion sequencer
// Assumes: control word mirrored from writes at address zero
// Notes: period check skips a sequence disturbed by a control write
`timescale 1ns/1ps
module ccs_seq_assertions (
	// Clock, reset and register port
	input wire logic        CLK, SYS_RST, REG_WR, REG_RD,
	input wire logic [9:0]  REG_ADDR,
	input wire logic [15:0] REG_WDATA, REG_RDATA,
	// Status
	input wire logic        SHUTDOWN, CONVERTING, SEQ_DONE,
	input wire logic        BTN_POS_ACTIVE, BTN_NEG_ACTIVE,
	input wire logic [3:0]  STAGE_INDEX
);
	logic [15:0] ctrl;
	logic [19:0] cnt;
	logic [19:0] per;
	logic [8:0]  dec;
	logic [3:0]  last;
	logic        clean;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// Control mirror and cycles since the last done pulse
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl <= 16'h0000;
			cnt <= 20'h0_0000;
			clean <= 1'b0;
		end else begin
			cnt <= SEQ_DONE ? 20'h0_0000 : cnt + 20'h0_0001;
			if (REG_WR && REG_ADDR == 10'h000) begin
				ctrl <= REG_WDATA;
				clean <= 1'b0;
			end else if (SEQ_DONE)
				clean <= 1'b1;
		end
	end
	// Clocks per sequence: stages x 3 x decimation x 100
	assign dec = ctrl[9] ? 9'h040 : ctrl[8] ? 9'h080 : 9'h100;
	assign last = (ctrl[7:4] > 4'hB) ? 4'hB : ctrl[7:4];
	assign per = (20'(last) + 20'h0_0001) * 20'(dec) * 20'h0_012C;
	property p_done_pulse; SEQ_DONE |=> !SEQ_DONE; endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done pulse too long");
	property p_btn_excl; !(BTN_POS_ACTIVE && BTN_NEG_ACTIVE); endproperty
	a_btn_excl: assert property (p_btn_excl)
		else $error("both buttons active");
	property p_shut_idle; SHUTDOWN |-> ##[0:3] !CONVERTING; endproperty
	a_shut_idle: assert property (p_shut_idle)
		else $error("converting in shutdown");
	property p_wrap;
		SEQ_DONE && ctrl[1:0] == 2'h0 |-> ##[1:2] STAGE_INDEX == 4'h0;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("no return to first stage");
	property p_stage_max; STAGE_INDEX <= 4'hB; endproperty
	a_stage_max: assert property (p_stage_max)
		else $error("stage index above 11");
	property p_step;
		$changed(STAGE_INDEX) |->
			STAGE_INDEX == $past(STAGE_INDEX) + 4'h1 || STAGE_INDEX == 4'h0;
	endproperty
	a_step: assert property (p_step)
		else $error("stage skipped");
	property p_period;
		SEQ_DONE && clean && ctrl[1:0] == 2'h0 |->
			cnt + 20'h0_0001 >= per && cnt <= per + 20'h0_00C8;
	endproperty
	a_period: assert property (p_period)
		else $error("sequence period wrong");
	property p_ctrl_rd;
		REG_RD && !REG_WR && REG_ADDR == 10'h000 |=>
			(REG_RDATA & 16'h1FFF) == ($past(ctrl) & 16'h1FFF);
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd)
		else $error("control readback wrong");
	c_done: cover property (SEQ_DONE);
	c_shut: cover property (SHUTDOWN && !CONVERTING);
	c_wake: cover property ($rose(CONVERTING) && ctrl[1:0] == 2'h2);
endmodule
bind ccs_sequencer ccs_seq_assertions u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SHUTDOWN(SHUTDOWN),
	.CONVERTING(CONVERTING), .SEQ_DONE(SEQ_DONE), .STAGE_INDEX(STAGE_INDEX),
	.BTN_POS_ACTIVE(BTN_POS_ACTIVE), .BTN_NEG_ACTIVE(BTN_NEG_ACTIVE));

// File: dv/testbench.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: 25 MHz clock, inputs driven on the falling edge
// Notes: decimation 64 keeps the run under 100k clocks
`timescale 1ns/1ps
module testbench;
	typedef struct packed {logic [9:0] a; logic [15:0] w, r;} ccs_row_t;
	logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, touch_req = 0;
	logic [9:0]  reg_addr = 10'h000;
	logic [1:0]  btn = 2'h3;
	logic [15:0] reg_wdata = 16'h0000, d;
	wire  [15:0] reg_rdata;
	wire  [25:0] routing;
	wire  [5:0]  pos, neg;
	wire  [3:0]  stage;
	wire         mod, tch, prx, bp, bn, shut, conv, done, bpa, bna;
	int          bad_count = 0, comparisons = 0, k;
	ccs_row_t    rows [6] = '{
		'{10'h000, 16'h0210, 16'h0210}, '{10'h080, 16'h1555, 16'h1555},
		'{10'h082, 16'h0AAA, 16'h0AAA}, '{10'h0A0, 16'h0FC5, 16'h0FC5},
		'{10'h0A1, 16'h0A13, 16'h0A13}, '{10'h3FF, 16'h1234, 16'h0000}};
	ccs_sequencer DUT (.CLK(clk), .SYS_RST(sys_rst), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_RDATA(reg_rdata), .MOD_BIT(mod), .TOUCH_PIN(tch), .PROX_PIN(prx),
		.BTN_POS_PIN(bp), .BTN_NEG_PIN(bn), .STAGE_INPUT_ROUTING(routing),
		.POSITIVE_OFFSET_DAC_CODE(pos), .NEGATIVE_OFFSET_DAC_CODE(neg),
		.SHUTDOWN(shut), .CONVERTING(conv), .STAGE_INDEX(stage),
		.SEQ_DONE(done), .BTN_POS_ACTIVE(bpa), .BTN_NEG_ACTIVE(bna));
	ccs_sense_model u_sense (.clk(clk), .touch_req(touch_req), .btn_req(btn),
		.mod_bit(mod), .touch(tch), .prox(prx), .btn_pos(bp), .btn_neg(bn));
	initial forever #20 clk = ~clk;
	task chk(input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [9:0] a, input logic [15:0] w);
		reg_addr = a;
		reg_wdata = w;
		reg_wr = 1;
		@(negedge clk);
		reg_wr = 0;
		@(negedge clk);
	endtask
	task rd(input logic [9:0] a, output logic [15:0] q);
		reg_addr = a;
		reg_rd = 1;
		@(negedge clk);
		reg_rd = 0;
		@(negedge clk);
		q = reg_rdata;
	endtask
	// Bounded wait; a missing pulse counts as a mismatch
	task wait_done(input int n);
		for (k = 0; k < n && done !== 1'b1; k++) @(negedge clk);
		chk({15'h0, done}, 16'h0001);
	endtask
	task finish_test;
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog sized a little above the longest path
	initial begin
		#4_400_000;
		bad_count++;
		finish_test;
	end
	initial begin
		repeat (5) @(negedge clk);
		sys_rst = 0;
		// Two stages used, so last stage is one
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a, d);
			chk(d, rows[i].r);
		end
		for (k = 0; k < 40000 && stage !== 4'h1; k++) @(negedge clk);
		repeat (2) @(negedge clk);
		chk({3'h0, routing[12:0]}, 16'h0AAA);
		chk({4'h0, neg, pos}, 16'h0A13);
		wait_done(40000);
		rd(10'h00B, d);
		chk(d, 16'h7FE0);
		chk({3'h0, routing[12:0]}, 16'h1555);
		chk({4'h0, neg, pos}, 16'h0FC5);
		wait_done(40000);
		wr(10'h000, 16'h0202);
		wait_done(20000);
		repeat (2) @(negedge clk);
		repeat (2000) begin
			@(negedge clk);
			chk({15'h0, conv}, 16'h0000);
		end
		touch_req = 1;
		for (k = 0; k < 300 && conv !== 1'b1; k++) @(negedge clk);
		chk({15'h0, conv}, 16'h0001);
		// Both shutdown codes abort the running sequence
		for (int m = 1; m < 4; m += 2) begin
			wr(10'h000, 16'h0200);
			for (k = 0; k < 300 && conv !== 1'b1; k++) @(negedge clk);
			chk({14'h0, shut, conv}, 16'h0001);
			wr(10'h000, 16'h0200 | 16'(m));
			repeat (4) @(negedge clk);
			chk({14'h0, shut, conv}, 16'h0002);
		end
		// Differential pair: both pressed, then each alone
		chk({14'h0, bpa, bna}, 16'h0000);
		btn = 2'h2;
		repeat (5) @(negedge clk);
		chk({14'h0, bpa, bna}, 16'h0002);
		btn = 2'h1;
		repeat (5) @(negedge clk);
		chk({14'h0, bpa, bna}, 16'h0001);
		finish_test;
	end
endmodule

// File: rtl/ccs_defs.vh
// Purpose: constants for the capacitance conversion sequencer
// Assumes: 25 MHz system clock, 250 kHz modulator sample rate
// Notes: register offsets, control field positions and wait timing counts live here; stage lengths are hard-coded in the sequencer
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH

// Register addresses
`define CCS_ADDR_CTRL        10'h000
`define CCS_ADDR_CFG         10'h001
`define CCS_ADDR_RES_FIRST   10'h00B
`define CCS_ADDR_RES_LAST    10'h016
`define CCS_ADDR_ROUTE_BASE  10'h080
`define CCS_ADDR_OFFS_BASE   10'h0A0

// Control register fields
`define CCS_MODE_LSB         0
`define CCS_WAKE_LSB         2
`define CCS_LAST_LSB         4
`define CCS_DECIM_LSB        8
`define CCS_PROX_EN_BIT      10
`define CCS_PROX_RATE_LSB    11
`define CCS_CTRL_RESET       16'h0000

// Mode encodings
`define CCS_MODE_FULL        2'b00
`define CCS_MODE_LOW         2'b10

// Timing: clock and sample rate
`define CCS_CLK_HZ           25000000
`define CCS_SAMPLE_HZ        250000
`define CCS_SAMPLE_DIV       (`CCS_CLK_HZ / `CCS_SAMPLE_HZ)
`define CCS_SAMPLES_PER_DEC  3
`define CCS_NUM_STAGES       12
`define CCS_NUM_INPUTS       13

// Timing in ms and derived sample counts (250 samples per ms)
`define CCS_WAKE_STEP_MS     200
`define CCS_ACTIVE_MS        36
`define CCS_SAMPLES_PER_MS   (`CCS_SAMPLE_HZ / 1000)
`define CCS_WAKE_STEP_SMP    (`CCS_WAKE_STEP_MS * `CCS_SAMPLES_PER_MS)
`define CCS_ACTIVE_SMP       (`CCS_ACTIVE_MS * `CCS_SAMPLES_PER_MS)

`endif

// File: rtl/ccs_sequencer.v
// Purpose: conversion sequencer for a 13-input capacitance converter
// Assumes: modulator outputs one sample bit per sample strobe
// Notes: register port is a simple synchronous parallel access
`timescale 1ns/1ps
`include "ccs_defs.vh"

module ccs_sequencer (
	// Clock and reset
	input  wire        CLK,
	input  wire        SYS_RST,
	// Register port
	input  wire        REG_WR,
	input  wire        REG_RD,
	input  wire [9:0]  REG_ADDR,
	input  wire [15:0] REG_WDATA,
	output reg  [15:0] REG_RDATA,
	// Modulator and sensing status, from the analog side
	input  wire        MOD_BIT,
	input  wire        TOUCH_PIN,
	input  wire        PROX_PIN,
	input  wire        BTN_POS_PIN,
	input  wire        BTN_NEG_PIN,
	// Analog controls
	output reg  [25:0] STAGE_INPUT_ROUTING,
	output reg  [5:0]  POSITIVE_OFFSET_DAC_CODE,
	output reg  [5:0]  NEGATIVE_OFFSET_DAC_CODE,
	output wire        SHUTDOWN,
	output reg         CONVERTING,
	// Status
	output reg  [3:0]  STAGE_INDEX,
	output reg         SEQ_DONE,
	output reg         BTN_POS_ACTIVE,
	output reg         BTN_NEG_ACTIVE
);

	localparam ST_IDLE = 2'd0;
	localparam ST_CONV = 2'd1;
	localparam ST_WAIT = 2'd2;

	// Counts are worked out at 32 bits, then cut to the counter widths
	localparam integer SAMPLE_DIV_I = `CCS_SAMPLE_DIV;
	localparam integer WAKE_STEP_I = `CCS_WAKE_STEP_SMP;
	localparam integer ACTIVE_SMP_I = `CCS_ACTIVE_SMP;
	localparam [6:0] SAMPLE_DIV = SAMPLE_DIV_I[6:0];
	localparam [17:0] WAKE_STEP = WAKE_STEP_I[17:0];
	localparam [17:0] ACTIVE_SMP = ACTIVE_SMP_I[17:0];

	reg  [15:0] power_and_conversion_control;
	reg  [15:0] stage_result [0:`CCS_NUM_STAGES-1];
	reg  [25:0] stage_input_routing [0:`CCS_NUM_STAGES-1];
	reg  [11:0] stage_frontend_offset [0:`CCS_NUM_STAGES-1];
	reg  [1:0]  state;
	reg  [6:0]  div_cnt;
	reg         sample_tick;
	reg  [9:0]  smp_cnt;
	reg  [15:0] ones_acc;
	reg  [17:0] wait_cnt;
	reg         awake;
	reg  [2:0]  touch_sync;
	reg  [2:0]  prox_sync;
	reg  [1:0]  bpos_sync;
	reg  [1:0]  bneg_sync;
	reg  [1:0]  mod_sync;
	reg  [9:0]  stage_len;
	reg  [17:0] wait_len;
	reg  [25:0] next_routing;
	wire [1:0]  mode;
	wire [1:0]  lowpower_wake_interval;
	wire [3:0]  last_stage;
	wire [1:0]  decim;
	wire        prox_en;
	wire [1:0]  prox_rate;
	wire        low_power;
	wire        touch;
	wire        prox;
	wire        stage_end;
	wire [25:0] routing_now;
	wire [15:0] result_now;
	wire [15:0] ones_sum;
	wire [11:0] offs_now;
	integer     i;
	integer     j;
	integer     n;

	// Control fields
	assign mode = power_and_conversion_control[`CCS_MODE_LSB +: 2];
	assign lowpower_wake_interval =
		power_and_conversion_control[`CCS_WAKE_LSB +: 2];
	assign last_stage = power_and_conversion_control[`CCS_LAST_LSB +: 4];
	assign decim = power_and_conversion_control[`CCS_DECIM_LSB +: 2];
	assign prox_en = power_and_conversion_control[`CCS_PROX_EN_BIT];
	assign prox_rate = power_and_conversion_control[`CCS_PROX_RATE_LSB +: 2];
	assign low_power = (mode == `CCS_MODE_LOW);
	assign SHUTDOWN = mode[0];
	assign touch = touch_sync[2];
	assign prox = prox_sync[2];

	// Stage length in samples: three times decimation
	always @* begin
		case (decim)
		2'b00:   stage_len = 10'd768;
		2'b01:   stage_len = 10'd384;
		default: stage_len = 10'd192;
		endcase
	end

	// Low power wait: wake interval while asleep, else active period
	always @* begin
		wait_len = WAKE_STEP *
			{16'h0000, lowpower_wake_interval + 2'd0} + WAKE_STEP;
		if (awake) begin
			if (prox_en) begin
				case (prox_rate)
				2'b01:   wait_len = ACTIVE_SMP >> 1;
				2'b10:   wait_len = ACTIVE_SMP >> 2;
				default: wait_len = ACTIVE_SMP;
				endcase
			end else begin
				wait_len = ACTIVE_SMP;
			end
		end
	end

	assign stage_end = sample_tick && (smp_cnt == stage_len - 10'd1);
	assign routing_now = stage_input_routing[STAGE_INDEX];
	assign offs_now = stage_frontend_offset[STAGE_INDEX];
	// Count includes this tick's sample, so no sample is lost at stage end
	assign ones_sum = ones_acc + {15'h0000, mod_sync[1]};
	// Average of samples, scaled to 16 bits per decimation setting
	assign result_now = (decim == 2'b00) ? ones_sum * 16'd85 :
		(decim == 2'b01) ? ones_sum * 16'd170 : ones_sum * 16'd341;

	// Synchronisers for pins from the analog side
	always @(posedge CLK) begin
		touch_sync <= {touch_sync[1:0], TOUCH_PIN};
		prox_sync <= {prox_sync[1:0], PROX_PIN};
		bpos_sync <= {bpos_sync[0], BTN_POS_PIN};
		bneg_sync <= {bneg_sync[0], BTN_NEG_PIN};
		mod_sync <= {mod_sync[0], MOD_BIT};
	end

	// Sample strobe at the modulator rate
	always @(posedge CLK) begin
		if (SYS_RST) begin
			div_cnt <= 7'd0;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= (div_cnt == SAMPLE_DIV - 7'd1);
			if (div_cnt == SAMPLE_DIV - 7'd1)
				div_cnt <= 7'd0;
			else
				div_cnt <= div_cnt + 7'd1;
		end
	end

	// Sequencer state machine
	always @(posedge CLK) begin
		if (SYS_RST) begin
			state <= ST_IDLE;
			STAGE_INDEX <= 4'd0;
			smp_cnt <= 10'd0;
			ones_acc <= 16'h0000;
			wait_cnt <= 18'd0;
			awake <= 1'b0;
			SEQ_DONE <= 1'b0;
			CONVERTING <= 1'b0;
			for (i = 0; i < `CCS_NUM_STAGES; i = i + 1)
				stage_result[i] <= 16'h0000;
		end else begin
			SEQ_DONE <= 1'b0;
			if (low_power && (touch || (prox_en && prox)))
				awake <= 1'b1;
			else if (!low_power)
				awake <= 1'b0;
			case (state)
			ST_IDLE: begin
				STAGE_INDEX <= 4'd0;
				if (!SHUTDOWN && sample_tick) begin
					state <= ST_CONV;
					CONVERTING <= 1'b1;
					smp_cnt <= 10'd0;
					ones_acc <= 16'h0000;
				end
			end
			ST_CONV: begin
				if (SHUTDOWN) begin
					state <= ST_IDLE;
					CONVERTING <= 1'b0;
				end else if (sample_tick) begin
					ones_acc <= ones_sum;
					smp_cnt <= smp_cnt + 10'd1;
					if (stage_end) begin
						// Store averaged result of this stage
						stage_result[STAGE_INDEX] <= result_now;
						smp_cnt <= 10'd0;
						ones_acc <= 16'h0000;
						if (STAGE_INDEX >= last_stage ||
						    STAGE_INDEX == 4'd11) begin
							SEQ_DONE <= 1'b1;
							STAGE_INDEX <= 4'd0;
							if (low_power) begin
								state <= ST_WAIT;
								CONVERTING <= 1'b0;
								wait_cnt <= 18'd0;
							end
						end else begin
							STAGE_INDEX <= STAGE_INDEX + 4'd1;
						end
					end
				end
			end
			ST_WAIT: begin
				if (!low_power) begin
					state <= ST_IDLE;
				end else if (!awake && (touch || (prox_en && prox))) begin
					// First touch while asleep starts at once, not on a tick
					state <= ST_CONV;
					CONVERTING <= 1'b1;
					smp_cnt <= 10'd0;
					ones_acc <= 16'h0000;
				end else if (sample_tick) begin
					if (wait_cnt >= wait_len - 18'd1) begin
						state <= ST_CONV;
						CONVERTING <= 1'b1;
						smp_cnt <= 10'd0;
						ones_acc <= 16'h0000;
					end else begin
						wait_cnt <= wait_cnt + 18'd1;
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// Routing and offsets follow the stage index
	always @* begin
		next_routing = routing_now;
	end

	always @(posedge CLK) begin
		if (SYS_RST) begin
			STAGE_INPUT_ROUTING <= 26'h000_0000;
			POSITIVE_OFFSET_DAC_CODE <= 6'h00;
			NEGATIVE_OFFSET_DAC_CODE <= 6'h00;
		end else begin
			STAGE_INPUT_ROUTING <= next_routing;
			POSITIVE_OFFSET_DAC_CODE <= offs_now[5:0];
			NEGATIVE_OFFSET_DAC_CODE <= offs_now[11:6];
		end
	end

	// Differential button pair: both pressed reports neither
	always @(posedge CLK) begin
		if (SYS_RST) begin
			BTN_POS_ACTIVE <= 1'b0;
			BTN_NEG_ACTIVE <= 1'b0;
		end else begin
			BTN_POS_ACTIVE <= bpos_sync[1] && !bneg_sync[1];
			BTN_NEG_ACTIVE <= bneg_sync[1] && !bpos_sync[1];
		end
	end

	// Register writes
	always @(posedge CLK) begin
		if (SYS_RST) begin
			power_and_conversion_control <= `CCS_CTRL_RESET;
			for (j = 0; j < `CCS_NUM_STAGES; j = j + 1) begin
				stage_input_routing[j] <= 26'h000_0000;
				stage_frontend_offset[j] <= 12'h000;
			end
		end else if (REG_WR) begin
			if (REG_ADDR == `CCS_ADDR_CTRL)
				power_and_conversion_control <= REG_WDATA;
			for (j = 0; j < `CCS_NUM_STAGES; j = j + 1) begin
				// Routing uses two words per stage: low then high
				if (REG_ADDR == `CCS_ADDR_ROUTE_BASE + 2 * j)
					stage_input_routing[j][12:0] <= REG_WDATA[12:0];
				if (REG_ADDR == `CCS_ADDR_ROUTE_BASE + 2 * j + 1)
					stage_input_routing[j][25:13] <= REG_WDATA[12:0];
				if (REG_ADDR == `CCS_ADDR_OFFS_BASE + j)
					stage_frontend_offset[j] <= REG_WDATA[11:0];
			end
		end
	end

	// Register reads, registered; unmapped reads return zero
	always @(posedge CLK) begin
		if (SYS_RST) begin
			REG_RDATA <= 16'h0000;
		end else if (REG_RD) begin
			REG_RDATA <= 16'h0000;
			if (REG_ADDR == `CCS_ADDR_CTRL)
				REG_RDATA <= power_and_conversion_control;
			if (REG_ADDR == `CCS_ADDR_CFG)
				REG_RDATA <= {9'h000, awake, CONVERTING, state[1:0],
					STAGE_INDEX[1:0] ^ STAGE_INDEX[3:2], 1'b0};
			for (n = 0; n < `CCS_NUM_STAGES; n = n + 1) begin
				if (REG_ADDR == `CCS_ADDR_RES_FIRST + n)
					REG_RDATA <= stage_result[n];
				if (REG_ADDR == `CCS_ADDR_ROUTE_BASE + 2 * n)
					REG_RDATA <= {3'h0, stage_input_routing[n][12:0]};
				if (REG_ADDR == `CCS_ADDR_ROUTE_BASE + 2 * n + 1)
					REG_RDATA <= {3'h0, stage_input_routing[n][25:13]};
				if (REG_ADDR == `CCS_ADDR_OFFS_BASE + n)
					REG_RDATA <= {4'h0, stage_frontend_offset[n]};
			end
		end
	end

endmodule
